// ### bench/cache_model.sv
// Purpose: split instruction and data cache stand-in
// Assumes: 64-word arrays, hits answered in the same cycle
// Notes: slow mode drops hits on a fixed pattern
`timescale 1ns/1ps
module cache_model
    import core_pkg::*;
(
    input wire logic sys_clk,
    input wire logic slow,
    input wire logic [31:0] imem_addr,
    output logic [31:0] imem_rdata,
    output logic imem_hit,
    input wire logic [31:0] dmem_addr,
    input wire logic dmem_rd,
    input wire logic dmem_wr,
    input wire logic [3:0] dmem_be,
    input wire logic [31:0] dmem_wdata,
    output logic [31:0] dmem_rdata,
    output logic dmem_hit
);
    logic [31:0] imem_a [0:63];
    logic [31:0] dmem_a [0:63];
    logic [7:0] cnt_ff = 8'h00;
    // free-running pattern for misses and idle data lines
    always @(posedge sys_clk)
        cnt_ff <= cnt_ff + 8'h01;
    // miss pattern: each port misses on its own cycles
    assign imem_hit = !slow || (cnt_ff[1:0] != 2'h3);
    assign dmem_hit = !slow || cnt_ff[0];
    // independent ports; no stale data while not answering
    assign imem_rdata = imem_hit ? imem_a[imem_addr[7:2]] : ~{4{cnt_ff}};
    assign dmem_rdata = (dmem_rd && dmem_hit) ?
        dmem_a[dmem_addr[7:2]] : {4{cnt_ff}};
    // byte-lane store on the completing edge
    always @(posedge sys_clk)
        if (dmem_wr && dmem_hit && imem_hit)
            for (int b = 0; b < 4; b++)
                if (dmem_be[b])
                    dmem_a[dmem_addr[7:2]][8*b +: 8] <= dmem_wdata[8*b +: 8];
endmodule

// ### bench/five_stage_risc_pipeline_tb.sv
// Purpose: program-level bench for the pipeline core
// Assumes: programs placed in the cache model while reset is held
// Notes: writebacks are logged in order and compared by index
`timescale 1ns/1ps
`define CHK(nm, ex, got) \
    begin \
        n_tests++; \
        if ((got) !== (ex)) \
        begin \
            num_errors++; \
            $display("ERROR %s exp %h got %h", nm, ex, got); \
        end \
    end
module five_stage_risc_pipeline_tb
    import core_pkg::*;
;
    logic sys_clk, rst, slow, imem_hit, dmem_rd, dmem_wr, dmem_hit;
    logic align_err, wb_valid;
    logic [31:0] imem_addr, imem_rdata, dmem_addr, dmem_wdata, dmem_rdata;
    logic [3:0] dmem_be;
    logic [4:0] wb_dst;
    logic [XLEN-1:0] wb_data;
    int num_errors = 0;
    int n_tests = 0;
    int wcnt, aerr_cnt;
    int edst[$];
    logic [XLEN-1:0] evl[$];
    logic [4:0] wq_dst [0:63];
    logic [XLEN-1:0] wq_dat [0:63];

    pipe_core pipe_core_inst (.sys_clk(sys_clk), .rst(rst),
        .imem_addr(imem_addr), .imem_rdata(imem_rdata), .imem_hit(imem_hit),
        .dmem_addr(dmem_addr), .dmem_rd(dmem_rd), .dmem_wr(dmem_wr),
        .dmem_be(dmem_be), .dmem_wdata(dmem_wdata), .dmem_rdata(dmem_rdata),
        .dmem_hit(dmem_hit), .align_err(align_err), .wb_valid(wb_valid),
        .wb_dst(wb_dst), .wb_data(wb_data));
    cache_model cache_model_inst (.sys_clk(sys_clk), .slow(slow),
        .imem_addr(imem_addr), .imem_rdata(imem_rdata), .imem_hit(imem_hit),
        .dmem_addr(dmem_addr), .dmem_rd(dmem_rd), .dmem_wr(dmem_wr),
        .dmem_be(dmem_be), .dmem_wdata(dmem_wdata), .dmem_rdata(dmem_rdata),
        .dmem_hit(dmem_hit));

    initial
    begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    // log each writeback on an advancing edge
    always @(posedge sys_clk)
        if (rst)
        begin
            wcnt <= 0;
            aerr_cnt <= 0;
        end
        else if (imem_hit && !((dmem_rd || dmem_wr) && !dmem_hit))
        begin
            if (wb_valid === 1'b1 && wcnt < 64)
            begin
                wq_dst[wcnt] <= wb_dst;
                wq_dat[wcnt] <= wb_data;
                wcnt <= wcnt + 1;
            end
            if (align_err === 1'b1)
                aerr_cnt <= aerr_cnt + 1;
        end

    function automatic logic [31:0] ri(logic [5:0] o, logic [4:0] s,
        logic [4:0] t, logic [15:0] m);
        return {o, s, t, m};
    endfunction
    function automatic logic [31:0] rr(logic [5:0] f, logic [4:0] s,
        logic [4:0] t, logic [4:0] d);
        return {OP_SPECIAL, s, t, d, 5'h00, f};
    endfunction
    // word i; d = dst (-1 no write, -2 never executed)
    task op(input int i, input logic [31:0] w, input int d,
        input logic [31:0] v);
        cache_model_inst.imem_a[i] = w;
        if (d != -2)
        begin
            edst.push_back(d);
            evl.push_back(XLEN'($signed(v)));
        end
    endtask
    task clr(input logic s);
        rst <= 1'b1;
        slow <= s;
        repeat (2) @(posedge sys_clk);
        for (int i = 0; i < 64; i++)
        begin
            cache_model_inst.imem_a[i] = 32'h00000000;
            cache_model_inst.dmem_a[i] = 32'h00000000;
        end
        edst.delete();
        evl.delete();
    endtask
    task run;
        rst <= 1'b0;
        for (int t = 0; t < 600 && wcnt < edst.size(); t++)
            @(posedge sys_clk);
        `CHK("wb_count", 1'b1, wcnt >= edst.size())
        for (int k = 0; k < edst.size(); k++)
            if (edst[k] >= 0)
            begin
                `CHK("wb_dst", 5'(edst[k]), wq_dst[k])
                `CHK("wb_data", evl[k], wq_dat[k])
            end
    endtask
    task scen_arith;
        clr(1'b0);
        op(0, ri(OP_LUI, 0, 1, 16'h1234), 1, 32'h12340000);
        op(1, ri(OP_ORI, 1, 1, 16'h5678), 1, 32'h12345678);
        op(2, ri(OP_ADDI, 0, 2, 16'hFFFF), 2, 32'hFFFFFFFF);
        op(3, rr(FN_ADD, 1, 2, 3), 3, 32'h12345677);
        op(4, ri(OP_ADDI, 0, 0, 16'h0005), -1, 32'h0);
        op(5, rr(FN_OR, 0, 0, 4), 4, 32'h00000000);
        op(6, rr(FN_SUB, 2, 1, 5), 5, 32'hEDCBA987);
        op(7, rr(FN_SLT, 2, 1, 6), 6, 32'h00000001);
        op(8, rr(FN_SLTU, 2, 1, 7), 7, 32'h00000000);
        op(9, ri(OP_ANDI, 2, 8, 16'h8000), 8, 32'h00008000);
        op(10, ri(OP_SPECIAL, 0, 1, {5'h09, 5'h04, FN_SLL}), 9, 32'h23456780);
        op(11, ri(OP_SPECIAL, 0, 5, {5'h0A, 5'h04, FN_SRA}), 10, 32'hFEDCBA98);
        op(12, ri(OP_SPECIAL, 0, 5, {5'h0B, 5'h04, FN_SRL}), 11, 32'h0EDCBA98);
        op(13, rr(FN_NOR, 1, 0, 12), 12, 32'hEDCBA987);
        op(14, rr(FN_AND, 1, 2, 13), 13, 32'h12345678);
        op(15, rr(FN_XOR, 1, 5, 14), 14, 32'hFFFFFFFF);
        op(16, ri(OP_SLTI, 2, 15, 16'h0000), 15, 32'h00000001);
        op(17, ri(OP_SLTIU, 1, 16, 16'hFFFF), 16, 32'h00000001);
        op(18, ri(OP_XORI, 1, 17, 16'hFFFF), 17, 32'h1234A987);
        run();
    endtask
    // loads spaced from their users
    task scen_mem(input logic s);
        clr(s);
        cache_model_inst.dmem_a[16] = 32'h80F17F82;
        op(0, ri(OP_ADDI, 0, 1, 16'h0044), 1, 32'h00000044);
        op(1, ri(OP_LB, 1, 2, 16'hFFFC), 2, 32'hFFFFFF82);
        op(2, ri(OP_LBU, 1, 3, 16'hFFFD), 3, 32'h0000007F);
        op(3, ri(OP_LH, 1, 4, 16'hFFFE), 4, 32'hFFFF80F1);
        op(4, ri(OP_LHU, 1, 5, 16'hFFFE), 5, 32'h000080F1);
        op(5, ri(OP_LW, 1, 6, 16'hFFFC), 6, 32'h80F17F82);
        op(6, ri(OP_SB, 1, 3, 16'h0005), -1, 32'h0);
        op(7, ri(OP_SW, 1, 6, 16'h0000), -1, 32'h0);
        op(8, ri(OP_LW, 1, 7, 16'h0000), 7, 32'h80F17F82);
        op(9, ri(OP_LW, 1, 8, 16'h0002), -1, 32'h0);
        op(10, ri(OP_SH, 1, 9, 16'h0001), -1, 32'h0);
        op(11, 32'h00000000, -1, 32'h0);
        op(12, rr(FN_OR, 8, 0, 10), 10, 32'h00000000);
        run();
        `CHK("word17", 32'h80F17F82, cache_model_inst.dmem_a[17])
        `CHK("word18", 32'h00007F00, cache_model_inst.dmem_a[18])
        `CHK("align_cnt", 2, aerr_cnt)
    endtask
    task scen_branch;
        clr(1'b0);
        op(0, ri(OP_ADDI, 0, 1, 16'hFFFF), 1, 32'hFFFFFFFF);
        op(1, ri(OP_ADDI, 0, 2, 16'h0001), 2, 32'h00000001);
        op(2, 32'h00000000, -1, 32'h0);
        op(3, ri(OP_BEQ, 2, 2, 16'h0002), -1, 32'h0);
        op(4, ri(OP_ADDI, 0, 3, 16'h0003), 3, 32'h00000003);
        op(5, ri(OP_ADDI, 0, 3, 16'h0005), -2, 32'h0);
        op(6, ri(OP_BNE, 2, 2, 16'h0005), -1, 32'h0);
        op(7, ri(OP_ADDI, 0, 4, 16'h0007), 4, 32'h00000007);
        op(8, ri(OP_REGIMM, 1, 0, 16'h0001), -1, 32'h0);
        op(9, ri(OP_ADDI, 0, 5, 16'h0009), 5, 32'h00000009);
        op(10, ri(OP_BGTZ, 1, 0, 16'h0005), -1, 32'h0);
        op(11, ri(OP_ADDI, 0, 6, 16'h000B), 6, 32'h0000000B);
        op(12, {OP_JUMP, 26'h0000014}, -1, 32'h0);
        op(13, ri(OP_ADDI, 0, 7, 16'h000D), 7, 32'h0000000D);
        op(14, ri(OP_ADDI, 0, 7, 16'h000E), -2, 32'h0);
        op(20, ri(OP_ADDI, 0, 8, 16'h0080), 8, 32'h00000080);
        op(21, 32'h00000000, -1, 32'h0);
        op(22, rr(FN_REG_JUMP, 8, 0, 0), -1, 32'h0);
        op(23, ri(OP_ADDI, 0, 9, 16'h0017), 9, 32'h00000017);
        op(24, ri(OP_ADDI, 0, 9, 16'h0018), -2, 32'h0);
        op(32, ri(OP_ADDI, 0, 10, 16'h0020), 10, 32'h00000020);
        op(33, ri(OP_REGIMM, 0, 1, 16'h0002), -1, 32'h0);
        op(34, ri(OP_ADDI, 0, 11, 16'h0022), 11, 32'h00000022);
        op(35, ri(OP_ADDI, 0, 11, 16'h0023), -2, 32'h0);
        op(36, ri(OP_BLEZ, 1, 0, 16'h0002), -1, 32'h0);
        op(37, ri(OP_ADDI, 0, 12, 16'h0025), 12, 32'h00000025);
        op(38, ri(OP_ADDI, 0, 12, 16'h0026), -2, 32'h0);
        op(39, ri(OP_ADDI, 0, 13, 16'h0027), 13, 32'h00000027);
        run();
    endtask
    task test_done;
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial
    begin
        rst = 1'b1;
        slow = 1'b0;
        scen_arith();
        scen_mem(1'b0);
        scen_mem(1'b1);
        scen_branch();
        test_done();
    end
    // hang guard, well beyond the expected run length
    initial
    begin
        #400000;
        num_errors++;
        test_done();
    end
endmodule

// ### bench/pipe_core_assertions.sv
// Purpose: port-level checks for the integer pipeline core
// Assumes: one clock domain, synchronous active-high reset
// Notes: stall means a cache miss of either port
`timescale 1ns/1ps
module pipe_core_assertions
    import core_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [31:0] imem_addr,
    input wire logic [31:0] imem_rdata,
    input wire logic imem_hit,
    input wire logic [31:0] dmem_addr,
    input wire logic dmem_rd,
    input wire logic dmem_wr,
    input wire logic [3:0] dmem_be,
    input wire logic [31:0] dmem_wdata,
    input wire logic [31:0] dmem_rdata,
    input wire logic dmem_hit,
    input wire logic align_err,
    input wire logic wb_valid,
    input wire logic [4:0] wb_dst,
    input wire logic [XLEN-1:0] wb_data
);
    logic acc;
    logic stall;
    // a data access in flight, and whether this edge advances
    assign acc = dmem_rd || dmem_wr;
    assign stall = !imem_hit || (acc && !dmem_hit);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    a_reset_idle: assert property (
        $fell(rst) |-> imem_addr == RESET_PC && !wb_valid && !acc
    ) else $error("core not idle after reset");
    a_first_result: assert property (
        $fell(rst) ##0 (!stall) [*5] |-> wb_valid && !$past(wb_valid)
            && !$past(wb_valid, 2) && !$past(wb_valid, 3)
    ) else $error("first writeback not in fifth cycle");
    a_steady_issue: assert property (
        wb_valid |=> wb_valid || stall
    ) else $error("gap in writeback stream without a miss");
    a_fetch_moves: assert property (
        !stall |=> !$stable(imem_addr)
    ) else $error("fetch address did not move");
    a_word_fetch: assert property (imem_addr[1:0] == 2'h0)
        else $error("fetch address not word aligned");
    a_stall_freeze: assert property (
        stall |=> $stable(imem_addr)
    ) else $error("fetch moved during a miss");
    a_access_hold: assert property (
        acc && stall |=> $stable({dmem_rd, dmem_wr, dmem_be, dmem_addr})
            && $stable(dmem_wdata)
    ) else $error("data access changed during a miss");
    a_one_access: assert property (!(dmem_rd && dmem_wr))
        else $error("read and write together");
    a_lane_align: assert property (
        acc |-> (dmem_be == 4'hF && dmem_addr[1:0] == 2'h0)
            || (dmem_be == (dmem_addr[1] ? 4'hC : 4'h3) && !dmem_addr[0])
            || dmem_be == (4'h1 << dmem_addr[1:0])
    ) else $error("byte enables do not match address");
    a_misalign_drop: assert property (align_err |-> !acc)
        else $error("misaligned access was sent");
    c_misalign: cover property (align_err);
    c_data_miss: cover property (acc && !dmem_hit);
    c_fetch_miss: cover property (wb_valid ##1 !imem_hit);
endmodule
bind pipe_core pipe_core_assertions pipe_core_assertions_inst (
    .sys_clk(sys_clk), .rst(rst), .imem_addr(imem_addr),
    .imem_rdata(imem_rdata), .imem_hit(imem_hit), .dmem_addr(dmem_addr),
    .dmem_rd(dmem_rd), .dmem_wr(dmem_wr), .dmem_be(dmem_be),
    .dmem_wdata(dmem_wdata), .dmem_rdata(dmem_rdata),
    .dmem_hit(dmem_hit), .align_err(align_err), .wb_valid(wb_valid),
    .wb_dst(wb_dst), .wb_data(wb_data)
);

// ### rtl/core_pkg.sv
// Purpose: shared constants and carriers for the integer pipeline core
// Assumes: 32-bit instruction words, 32 general registers
// Notes: XLEN selects a 32-bit or 64-bit register width
package core_pkg;
    localparam int XLEN = 32;
    localparam int NREG = 32;
    localparam logic [31:0] RESET_PC = 32'h0000_0000;
    localparam logic [31:0] INSTR_BYTES = 32'h0000_0004;
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int OPC_LSB = 26;
    localparam int RS_LSB = 21;
    localparam int RT_LSB = 16;
    localparam int RD_LSB = 11;
    localparam int SH_LSB = 6;
    // ------------------------------------------------------------
    // major opcodes
    // ------------------------------------------------------------
    localparam logic [5:0] OP_SPECIAL = 6'h00;
    localparam logic [5:0] OP_REGIMM = 6'h01;
    localparam logic [5:0] OP_JUMP = 6'h02;
    localparam logic [5:0] OP_BEQ = 6'h04;
    localparam logic [5:0] OP_BNE = 6'h05;
    localparam logic [5:0] OP_BLEZ = 6'h06;
    localparam logic [5:0] OP_BGTZ = 6'h07;
    localparam logic [5:0] OP_ADDI = 6'h08;
    localparam logic [5:0] OP_SLTI = 6'h0A;
    localparam logic [5:0] OP_SLTIU = 6'h0B;
    localparam logic [5:0] OP_ANDI = 6'h0C;
    localparam logic [5:0] OP_ORI = 6'h0D;
    localparam logic [5:0] OP_XORI = 6'h0E;
    localparam logic [5:0] OP_LUI = 6'h0F;
    localparam logic [5:0] OP_LB = 6'h20;
    localparam logic [5:0] OP_LH = 6'h21;
    localparam logic [5:0] OP_LW = 6'h23;
    localparam logic [5:0] OP_LBU = 6'h24;
    localparam logic [5:0] OP_LHU = 6'h25;
    localparam logic [5:0] OP_SB = 6'h28;
    localparam logic [5:0] OP_SH = 6'h29;
    localparam logic [5:0] OP_SW = 6'h2B;
    // ------------------------------------------------------------
    // function codes under OP_SPECIAL
    // ------------------------------------------------------------
    localparam logic [5:0] FN_SLL = 6'h00;
    localparam logic [5:0] FN_SRL = 6'h02;
    localparam logic [5:0] FN_SRA = 6'h03;
    localparam logic [5:0] FN_REG_JUMP = 6'h08;
    localparam logic [5:0] FN_ADD = 6'h20;
    localparam logic [5:0] FN_SUB = 6'h22;
    localparam logic [5:0] FN_AND = 6'h24;
    localparam logic [5:0] FN_OR = 6'h25;
    localparam logic [5:0] FN_XOR = 6'h26;
    localparam logic [5:0] FN_NOR = 6'h27;
    localparam logic [5:0] FN_SLT = 6'h2A;
    localparam logic [5:0] FN_SLTU = 6'h2B;

    typedef enum {ALU_ADD, ALU_SUB, ALU_AND, ALU_OR, ALU_XOR, ALU_NOR,
        ALU_SLT, ALU_SLTU, ALU_SLL, ALU_SRL, ALU_SRA, ALU_LUI} alu_op_t;
    typedef enum {SZ_B, SZ_H, SZ_W} mem_size_t;

    typedef struct packed {
        logic valid;
        logic [31:0] pc;
        logic [31:0] instr;
    } fetch_t;
    typedef struct packed {
        logic valid;
        alu_op_t op;
        logic [XLEN-1:0] a;
        logic [XLEN-1:0] b;
        logic [XLEN-1:0] st;
        logic [4:0] dst;
        logic wr;
        logic ld;
        logic sto;
        mem_size_t sz;
        logic uns;
    } exec_t;
    typedef struct packed {
        logic valid;
        logic [XLEN-1:0] res;
        logic [XLEN-1:0] st;
        logic [4:0] dst;
        logic wr;
        logic ld;
        logic sto;
        mem_size_t sz;
        logic uns;
    } mem_t;
    typedef struct packed {
        logic valid;
        logic [XLEN-1:0] res;
        logic [4:0] dst;
        logic wr;
    } wb_t;
endpackage

// ### rtl/pipe_core.sv
// Purpose: five-stage integer pipeline with split instruction/data caches
// Assumes: cache hit flags from same clock; no exceptions, no mul/div
// Notes: misaligned accesses are dropped and flagged on align_err
`timescale 1ns/1ps

// Function
// - every instruction walks fetch, read, alu, memory, writeback in order
// - one new instruction starts each clock while caches hit
// - fetch reads instruction cache, independent of data cache port
// - read stage decodes and reads all named source registers
// - integer alu operations finish in one clock
// - data cache accessed only from the memory stage
// - writeback stores at most one register per instruction
// - every instruction is one 32-bit word
// - only loads and stores touch memory, data arrives in stage four
// - 32 registers, arithmetic names two sources and one destination
// - register zero always reads as zero
// - no condition flags; branches test sign/zero or equality
// - immediates are 16 bits; upper-immediate load builds high half
// - effective address is base register plus signed 16-bit offset
// - byte and halfword loads sign-extend or zero-extend
// - words four-byte aligned, halfwords two-byte aligned
// - jump target is 26 bits shifted two within current 256MB segment
// - register indirect jump takes whole target from a register
// - branch offset is signed word count from the following instruction
// - 32-bit results sign-extend into a wider register
// - instruction after a jump or branch always executes
module pipe_core
    import core_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    output logic [31:0] imem_addr,
    input wire logic [31:0] imem_rdata,
    input wire logic imem_hit,
    output logic [31:0] dmem_addr,
    output logic dmem_rd,
    output logic dmem_wr,
    output logic [3:0] dmem_be,
    output logic [31:0] dmem_wdata,
    input wire logic [31:0] dmem_rdata,
    input wire logic dmem_hit,
    output logic align_err,
    output logic wb_valid,
    output logic [4:0] wb_dst,
    output logic [XLEN-1:0] wb_data
);
    // refuse register widths the datapath cannot serve
    if (XLEN != 32 && XLEN != 64)
        $error("XLEN must be 32 or 64");

    logic [31:0] pc_ff;
    fetch_t fd_ff;
    exec_t de_ff, nxt_de;
    mem_t em_ff;
    wb_t mw_ff;
    logic [XLEN-1:0] regs_ff [NREG];
    logic stall, redirect, mis, mem_req;
    logic [31:0] target;
    logic [XLEN-1:0] ex_res, mem_res;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [XLEN-1:0] sx(input logic [31:0] v);
        return XLEN'($signed(v));
    endfunction

    function automatic logic [XLEN-1:0] alu(input alu_op_t op,
        input logic [XLEN-1:0] a, input logic [XLEN-1:0] b);
        case (op)
            ALU_ADD: return sx(a[31:0] + b[31:0]);
            ALU_SUB: return sx(a[31:0] - b[31:0]);
            ALU_AND: return a & b;
            ALU_OR: return a | b;
            ALU_XOR: return a ^ b;
            ALU_NOR: return ~(a | b);
            ALU_SLT: return XLEN'($signed(a) < $signed(b));
            ALU_SLTU: return XLEN'(a < b);
            ALU_SLL: return sx(a[31:0] << b[4:0]);
            ALU_SRL: return sx(a[31:0] >> b[4:0]);
            ALU_SRA: return sx(32'($signed(a[31:0]) >>> b[4:0]));
            ALU_LUI: return sx({b[15:0], 16'h0000});
            default: return '0;
        endcase
    endfunction

    // newest producer wins; register zero never forwards
    function automatic logic [XLEN-1:0] src(input logic [4:0] r);
        if (r == 5'h00)
            return '0;
        if (de_ff.valid && de_ff.wr && de_ff.dst == r)
            return ex_res;
        if (em_ff.valid && em_ff.wr && em_ff.dst == r)
            return mem_res;
        if (mw_ff.valid && mw_ff.wr && mw_ff.dst == r)
            return mw_ff.res;
        return regs_ff[r];
    endfunction

    // ------------------------------------------------------------
    // stall control
    // ------------------------------------------------------------
    assign mem_req = em_ff.valid && (em_ff.ld || em_ff.sto) && !mis;
    assign stall = !imem_hit || (mem_req && !dmem_hit);

    // ------------------------------------------------------------
    // fetch stage
    // ------------------------------------------------------------
    assign imem_addr = pc_ff;

    // pc advances one word per clock unless frozen or redirected to the transfer target
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            pc_ff <= RESET_PC;
        else if (!stall)
            pc_ff <= redirect ? target : pc_ff + INSTR_BYTES;
    end

    // slot after a taken transfer is already fetched and kept
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            fd_ff <= '0;
        else if (!stall)
            fd_ff <= '{valid: 1'b1, pc: pc_ff, instr: imem_rdata};
    end

    // ------------------------------------------------------------
    // register read and decode stage
    // ------------------------------------------------------------
    always_comb
    begin
        logic [5:0] opc, fn;
        logic [4:0] rs, rt, rd;
        logic [XLEN-1:0] va, vb, simm, zimm;
        logic [31:0] seq;
        logic take;
        opc = fd_ff.instr[OPC_LSB +: 6];
        fn = fd_ff.instr[5:0];
        rs = fd_ff.instr[RS_LSB +: 5];
        rt = fd_ff.instr[RT_LSB +: 5];
        rd = fd_ff.instr[RD_LSB +: 5];
        va = src(rs);
        vb = src(rt);
        simm = XLEN'($signed(fd_ff.instr[15:0]));
        zimm = XLEN'(fd_ff.instr[15:0]);
        seq = fd_ff.pc + INSTR_BYTES;
        take = 1'b0;
        target = seq + {{14{fd_ff.instr[15]}}, fd_ff.instr[15:0], 2'b00};
        nxt_de = '0;
        nxt_de.valid = fd_ff.valid;
        nxt_de.op = ALU_ADD;
        nxt_de.a = va;
        nxt_de.b = simm;
        nxt_de.st = vb;
        nxt_de.dst = rt;
        nxt_de.sz = SZ_W;
        case (opc)
            OP_SPECIAL:
            begin
                nxt_de.b = vb;
                nxt_de.dst = rd;
                nxt_de.wr = 1'b1;
                case (fn)
                    FN_ADD: nxt_de.op = ALU_ADD;
                    FN_SUB: nxt_de.op = ALU_SUB;
                    FN_AND: nxt_de.op = ALU_AND;
                    FN_OR: nxt_de.op = ALU_OR;
                    FN_XOR: nxt_de.op = ALU_XOR;
                    FN_NOR: nxt_de.op = ALU_NOR;
                    FN_SLT: nxt_de.op = ALU_SLT;
                    FN_SLTU: nxt_de.op = ALU_SLTU;
                    FN_SLL, FN_SRL, FN_SRA:
                    begin
                        nxt_de.op = fn == FN_SLL ? ALU_SLL :
                            fn == FN_SRL ? ALU_SRL : ALU_SRA;
                        nxt_de.a = vb;
                        nxt_de.b = XLEN'(fd_ff.instr[SH_LSB +: 5]);
                    end
                    FN_REG_JUMP:
                    begin
                        nxt_de.wr = 1'b0;
                        take = 1'b1;
                        target = va[31:0];
                    end
                    default: nxt_de.wr = 1'b0;
                endcase
            end
            OP_JUMP:
            begin
                take = 1'b1;
                target = {seq[31:28], fd_ff.instr[25:0], 2'b00};
            end
            // no flags: tests look at register values only
            OP_BEQ: take = va == vb;
            OP_BNE: take = va != vb;
            OP_BLEZ: take = va[XLEN-1] || va == '0;
            OP_BGTZ: take = !va[XLEN-1] && va != '0;
            OP_REGIMM: take = va[XLEN-1] ^ rt[0];
            OP_ADDI, OP_SLTI, OP_SLTIU, OP_ANDI, OP_ORI, OP_XORI, OP_LUI:
            begin
                nxt_de.wr = 1'b1;
                case (opc)
                    OP_SLTI: nxt_de.op = ALU_SLT;
                    OP_SLTIU: nxt_de.op = ALU_SLTU;
                    OP_ANDI: nxt_de.op = ALU_AND;
                    OP_ORI: nxt_de.op = ALU_OR;
                    OP_XORI: nxt_de.op = ALU_XOR;
                    OP_LUI: nxt_de.op = ALU_LUI;
                    default: nxt_de.op = ALU_ADD;
                endcase
                if (opc == OP_ANDI || opc == OP_ORI || opc == OP_XORI)
                    nxt_de.b = zimm;
            end
            // base plus signed offset is the only address form
            OP_LB, OP_LH, OP_LW, OP_LBU, OP_LHU:
            begin
                nxt_de.wr = 1'b1;
                nxt_de.ld = 1'b1;
                nxt_de.uns = opc == OP_LBU || opc == OP_LHU;
                nxt_de.sz = opc == OP_LW ? SZ_W :
                    (opc == OP_LH || opc == OP_LHU) ? SZ_H : SZ_B;
            end
            OP_SB, OP_SH, OP_SW:
            begin
                nxt_de.sto = 1'b1;
                nxt_de.sz = opc == OP_SW ? SZ_W :
                    opc == OP_SH ? SZ_H : SZ_B;
            end
            default: nxt_de.wr = 1'b0;
        endcase
        if (nxt_de.dst == 5'h00)
            nxt_de.wr = 1'b0;
        redirect = fd_ff.valid && take;
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            de_ff <= '0;
        else if (!stall)
            de_ff <= nxt_de;
    end

    // ------------------------------------------------------------
    // alu stage
    // ------------------------------------------------------------
    assign ex_res = alu(de_ff.op, de_ff.a, de_ff.b);

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            em_ff <= '0;
        else if (!stall)
            em_ff <= '{valid: de_ff.valid, res: ex_res, st: de_ff.st,
                dst: de_ff.dst, wr: de_ff.wr, ld: de_ff.ld,
                sto: de_ff.sto, sz: de_ff.sz, uns: de_ff.uns};
    end

    // ------------------------------------------------------------
    // memory stage
    // ------------------------------------------------------------
    // misaligned halfword or word accesses are dropped
    assign mis = (em_ff.sz == SZ_H && em_ff.res[0]) ||
        (em_ff.sz == SZ_W && em_ff.res[1:0] != 2'b00);
    assign align_err = em_ff.valid && (em_ff.ld || em_ff.sto) && mis;
    assign dmem_addr = em_ff.res[31:0];
    assign dmem_rd = mem_req && em_ff.ld;
    assign dmem_wr = mem_req && em_ff.sto;

    // byte lanes and replicated store data
    always_comb
    begin
        case (em_ff.sz)
            SZ_B:
            begin
                dmem_be = 4'h1 << em_ff.res[1:0];
                dmem_wdata = {4{em_ff.st[7:0]}};
            end
            SZ_H:
            begin
                dmem_be = em_ff.res[1] ? 4'hC : 4'h3;
                dmem_wdata = {2{em_ff.st[15:0]}};
            end
            default:
            begin
                dmem_be = 4'hF;
                dmem_wdata = em_ff.st[31:0];
            end
        endcase
    end

    // lane pick and extension of load data
    always_comb
    begin
        logic [7:0] bt;
        logic [15:0] hw;
        bt = dmem_rdata[8 * em_ff.res[1:0] +: 8];
        hw = dmem_rdata[16 * em_ff.res[1] +: 16];
        if (!em_ff.ld)
            mem_res = em_ff.res;
        else if (em_ff.sz == SZ_B)
            mem_res = em_ff.uns ? XLEN'(bt) : XLEN'($signed(bt));
        else if (em_ff.sz == SZ_H)
            mem_res = em_ff.uns ? XLEN'(hw) : XLEN'($signed(hw));
        else
            mem_res = sx(dmem_rdata);
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
            mw_ff <= '0;
        else if (!stall)
            mw_ff <= '{valid: em_ff.valid, res: mem_res, dst: em_ff.dst,
                wr: em_ff.wr && !(em_ff.ld && mis)};
    end

    // ------------------------------------------------------------
    // writeback stage
    // ------------------------------------------------------------
    // single destination per instruction, zero register never written
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            regs_ff <= '{default: '0};
        else if (mw_ff.valid && mw_ff.wr && mw_ff.dst != 5'h00)
            regs_ff[mw_ff.dst] <= mw_ff.res;
    end

    assign wb_valid = mw_ff.valid && !stall;
    assign wb_dst = mw_ff.dst;
    assign wb_data = mw_ff.res;
endmodule
